// [src/fault_notify.sv]
// Fault notification, enable handling and primary reset events.
// Assumes an APB master on clk_i and a host driving the enable and reset pins.
// Operation
// [RULE_01] Three active-low fault pins, bits readable; code reads back fault A and B only, not the reset pin
// [RULE_02] Reset, class A, class B pins
// [RULE_03] Class A active-to-disabled asserts fault A
// [RULE_04] Class A without transition: sticky only
// [RULE_05] Monitor disable blocks monitor events
// [RULE_06] Alarm-off: disable input sets sticky only
// [RULE_07] Status rising edges assert fault A
// [RULE_08] Both alarms off: transitions only
// [RULE_09] Class B into fault mode asserts B
// [RULE_10] Class B without transition: sticky only
// [RULE_11] Clear primary drops pins, primary bits
// [RULE_12] Clear secondary; fault mode to reset
// [RULE_13] Enable valid clears pins in disabled modes
// [RULE_14] Report driven and read-back pin levels
// [RULE_15] Enable low means disabled state
// [RULE_16] Enable falling edge raises class A
// [RULE_17] Enable level and validity status bits
// [RULE_18] Reset restores default configuration
// [RULE_19] Host reset sets reset flags
// [RULE_20] Undervoltage or oscillator drives reset low
// [RULE_21] Reset end raises class B
// [RULE_22] Secondary soft reset, PWM off, comm error
// [RULE_23] Every reset enters reset mode
// [RULE_24] Synchronise inputs, register status copies
`timescale 1ns/1ps
`default_nettype none
module fault_notify
    import fault_notify_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic enable_i,
    input wire logic output_disable_in_i,
    input wire logic primary_undervoltage_i,
    input wire logic primary_oscillator_fail_i,
    input wire logic lifesign_lost_i,
    input wire logic fault_a_n_i,
    input wire logic fault_b_n_i,
    input wire logic reset_ready_n_i,
    output logic fault_a_n_o,
    output logic fault_a_n_oe_o,
    output logic fault_b_n_o,
    output logic fault_b_n_oe_o,
    output logic reset_ready_n_o,
    output logic reset_ready_n_oe_o,
    output logic output_tristate_o,
    output logic pwm_off_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [4:0] sync_q;
    logic enable_s, disable_in_s, rst_pin_n_s, fault_a_pin_s;
    logic enable_d_ff, disable_in_d_ff, rst_pin_n_d_ff;
    logic [7:0] cfg_ff;
    logic [5:0] pri_err_ff;
    logic [3:0] sec_err_ff;
    logic [2:0] ctl_ff;
    op_mode_e mode_ff, nxt_mode;
    logic tristate_ctrl_ff, tristate_ctrl_d_ff, pri_tri_d_ff;
    logic in_reset_ff, ext_reset_ff, hold_fault_b_ff;
    logic fault_a_ff, fault_b_ff, nxt_fault_a, nxt_fault_b;
    logic fault_b_pin_s;
    logic [4:0] ev_ff;
    logic wr, rd_ok;
    logic int_cause, any_reset, reset_end, host_rst;
    logic [1:0] own_drv_ff;
    logic en_fall, en_rise, dis_rise, dis_fall;
    logic cls_a, cls_b, a_trans, b_trans, tri_now;
    logic clr_p, clr_s, monitor_ev;

    // Pin levels are read back through the synchroniser as well
    sync_two #(.WIDTH(5), .INIT(5'h13)) u_sync ( // see [RULE_24]
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i({reset_ready_n_i, output_disable_in_i, enable_i, fault_a_n_i, fault_b_n_i}),
        .q_o(sync_q)
    );
    assign {rst_pin_n_s, disable_in_s, enable_s, fault_a_pin_s, fault_b_pin_s} = sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // Reset events
    function automatic logic is_mode(op_mode_e m, op_mode_e a, op_mode_e b);
        return (m == a) || (m == b);
    endfunction

    // Host pulls low: external. Own causes: undervoltage, oscillator.
    assign int_cause = primary_undervoltage_i | primary_oscillator_fail_i; // see [RULE_20]
    // Own drive reads back low two more edges: not a host reset
    assign host_rst = ~rst_pin_n_s & ~reset_ready_n_oe_o & ~|own_drv_ff; // see [RULE_19]
    assign any_reset = int_cause | host_rst | ctl_ff[SOFT_RESET_BIT];
    assign reset_end = in_reset_ff & ~any_reset;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            in_reset_ff <= 1'b0;
            ext_reset_ff <= 1'b0;
        end
        else
        begin
            in_reset_ff <= any_reset;
            if (host_rst && !int_cause)
                ext_reset_ff <= 1'b1; // see [RULE_19]
            else if (reset_end)
                ext_reset_ff <= 1'b0;
        end
    end

    // Own drive of the reset pin only while the own cause lasts
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            reset_ready_n_o <= 1'b0;
            reset_ready_n_oe_o <= 1'b1;
            own_drv_ff <= 2'b11;
        end
        else
        begin
            reset_ready_n_o <= 1'b0;
            reset_ready_n_oe_o <= int_cause; // see [RULE_02] [RULE_20]
            own_drv_ff <= {own_drv_ff[0], reset_ready_n_oe_o};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edges and events
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            enable_d_ff <= 1'b0;
            disable_in_d_ff <= 1'b0;
            rst_pin_n_d_ff <= 1'b1;
            tristate_ctrl_d_ff <= 1'b0;
            pri_tri_d_ff <= 1'b0;
        end
        else
        begin
            enable_d_ff <= enable_s;
            disable_in_d_ff <= disable_in_s;
            rst_pin_n_d_ff <= rst_pin_n_s;
            tristate_ctrl_d_ff <= tristate_ctrl_ff; // see [RULE_24]
            pri_tri_d_ff <= pri_err_ff[PRI_TRISTATE_BIT];
        end
    end

    assign en_fall = enable_d_ff & ~enable_s;
    assign en_rise = ~enable_d_ff & enable_s;
    assign dis_rise = ~disable_in_d_ff & disable_in_s;
    assign dis_fall = disable_in_d_ff & ~disable_in_s;
    assign monitor_ev = ev_ff[EV_MONITOR_FAULT_BIT] & ~cfg_ff[MONITOR_DISABLE_BIT]; // see [RULE_05]
    assign cls_a = en_fall // see [RULE_16]
        | monitor_ev
        | (dis_rise & ~cfg_ff[DISABLE_ALARM_OFF_BIT]) // see [RULE_06]
        | ev_ff[EV_CLASS_A_PRI_BIT] | ev_ff[EV_CLASS_A_SEC_BIT];
    assign cls_b = ev_ff[EV_CLASS_B_PRI_BIT] | ev_ff[EV_CLASS_B_SEC_BIT] | reset_end; // see [RULE_21]
    assign tri_now = tristate_ctrl_ff | disable_in_s;
    assign clr_p = ctl_ff[0];
    assign clr_s = ctl_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // Operating mode
    always_comb
    begin
        nxt_mode = mode_ff;
        a_trans = 1'b0;
        b_trans = 1'b0;
        case (mode_ff)
            RESET_MODE:
                nxt_mode = cfg_ff[ENABLE_SECOND_BIT] ? DISABLED_MODE_B : DISABLED_MODE_A;
            FAULT_MODE:
                if (clr_s)
                    nxt_mode = RESET_MODE; // see [RULE_12]
            DISABLED_MODE_A, DISABLED_MODE_B:
                // Validity alone is not enough: any pending class A holds off
                if (enable_s && !cls_a && !fault_a_ff && !tri_now) // see [RULE_15] [RULE_17]
                    nxt_mode = (mode_ff == DISABLED_MODE_A) ? ACTIVE_MODE_A : ACTIVE_MODE_B;
            ACTIVE_MODE_A, ACTIVE_MODE_B:
                if (cls_a || !enable_s)
                begin
                    a_trans = cls_a; // see [RULE_03]
                    nxt_mode = (mode_ff == ACTIVE_MODE_A) ? DISABLED_MODE_A : DISABLED_MODE_B;
                end
            default:
                nxt_mode = RESET_MODE;
        endcase
        if (cls_b && mode_ff != FAULT_MODE)
        begin
            b_trans = 1'b1; // see [RULE_09] [RULE_10]
            a_trans = 1'b0;
            nxt_mode = FAULT_MODE;
        end
        if (any_reset)
        begin
            a_trans = 1'b0;
            b_trans = 1'b0;
            nxt_mode = RESET_MODE; // see [RULE_23]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            mode_ff <= RESET_MODE;
        else
            mode_ff <= nxt_mode;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault pins: set wins over clear, except that a reset clears fault A
    always_comb
    begin
        nxt_fault_a = fault_a_ff;
        nxt_fault_b = fault_b_ff;
        if (clr_p) // see [RULE_11]
        begin
            nxt_fault_a = 1'b0;
            nxt_fault_b = 1'b0;
        end
        if (en_rise && is_mode(mode_ff, DISABLED_MODE_A, DISABLED_MODE_B)) // see [RULE_13]
        begin
            nxt_fault_a = 1'b0;
            nxt_fault_b = 1'b0;
        end
        if (a_trans // see [RULE_04] [RULE_08]
            || (cfg_ff[TRISTATE_ALARM_EN_BIT] && pri_err_ff[PRI_TRISTATE_BIT] && !pri_tri_d_ff)
            || (cfg_ff[MONITOR_ALARM_EN_BIT] && tristate_ctrl_ff && !tristate_ctrl_d_ff))
            nxt_fault_a = 1'b1; // see [RULE_07]
        if (b_trans || hold_fault_b_ff)
            nxt_fault_b = 1'b1;
        if (any_reset)
            nxt_fault_a = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            fault_a_ff <= 1'b0;
            fault_b_ff <= 1'b1;
            hold_fault_b_ff <= 1'b0;
        end
        else
        begin
            fault_a_ff <= nxt_fault_a;
            // Fault B held low through the reset, kept for class B at its end
            fault_b_ff <= any_reset | nxt_fault_b;
            hold_fault_b_ff <= reset_end; // see [RULE_21]
        end
    end

    // Open-drain style: drive low only
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            fault_a_n_o <= 1'b0;
            fault_a_n_oe_o <= 1'b0;
            fault_b_n_o <= 1'b0;
            fault_b_n_oe_o <= 1'b1;
        end
        else
        begin
            fault_a_n_o <= 1'b0;
            fault_a_n_oe_o <= nxt_fault_a; // see [RULE_01] [RULE_02]
            fault_b_n_o <= 1'b0;
            fault_b_n_oe_o <= any_reset | nxt_fault_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tristate control and output stage
    always_ff @(posedge clk_i)
    begin
        if (reset_i || any_reset)
            tristate_ctrl_ff <= 1'b0;
        else if (monitor_ev)
            tristate_ctrl_ff <= 1'b1;
        else if (dis_fall)
            tristate_ctrl_ff <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            output_tristate_o <= 1'b0;
            pwm_off_o <= 1'b1;
        end
        else
        begin
            // Disable input stays effective during reset
            output_tristate_o <= tri_now; // see [RULE_06] [RULE_22]
            pwm_off_o <= any_reset | ~is_mode(nxt_mode, ACTIVE_MODE_A, ACTIVE_MODE_B);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky errors: clear by control bit, event set wins
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            pri_err_ff <= PRI_ERR_RESET;
        else
        begin
            if (clr_p)
                pri_err_ff <= PRI_ERR_RESET;
            if (tri_now)
                pri_err_ff[PRI_TRISTATE_BIT] <= 1'b1;
            if (en_fall || monitor_ev || ev_ff[EV_CLASS_A_PRI_BIT])
                pri_err_ff[PRI_CLASS_A_BIT] <= 1'b1; // see [RULE_04]
            if (ev_ff[EV_CLASS_B_PRI_BIT] || reset_end)
                pri_err_ff[PRI_CLASS_B_BIT] <= 1'b1; // see [RULE_10]
            if (reset_end)
            begin
                pri_err_ff[PRI_RESET_BIT] <= 1'b1; // see [RULE_19] [RULE_20]
                pri_err_ff[PRI_EXT_RESET_BIT] <= ext_reset_ff;
                pri_err_ff[PRI_COMM_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            sec_err_ff <= SEC_ERR_RESET;
        else
        begin
            if (clr_s)
                sec_err_ff <= SEC_ERR_RESET; // see [RULE_12]
            if (tri_now)
                sec_err_ff[SEC_TRISTATE_BIT] <= 1'b1; // see [RULE_06]
            if (any_reset && lifesign_lost_i)
                sec_err_ff[SEC_COMM_BIT] <= 1'b1; // see [RULE_22]
            if (ev_ff[EV_CLASS_A_SEC_BIT])
                sec_err_ff[SEC_CLASS_A_BIT] <= 1'b1;
            if (ev_ff[EV_CLASS_B_SEC_BIT])
                sec_err_ff[SEC_CLASS_B_BIT] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign wr = psel_i & penable_i & pwrite_i;
    assign rd_ok = (paddr_i == CFG_OFF) || (paddr_i == CTRL_OFF) || (paddr_i == PRI_ERR_OFF)
        || (paddr_i == SEC_ERR_OFF) || (paddr_i == STATUS_OFF) || (paddr_i == PIN_OFF)
        || (paddr_i == EVENT_OFF);

    always_ff @(posedge clk_i)
    begin
        if (reset_i || any_reset)
            cfg_ff <= CFG_RESET; // see [RULE_18]
        else if (wr && paddr_i == CFG_OFF)
            cfg_ff <= pwdata_i[7:0];
    end

    // Control and event bits are one-cycle pulses
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ctl_ff <= 3'h0;
            ev_ff <= 5'h00;
        end
        else
        begin
            ctl_ff <= (wr && paddr_i == CTRL_OFF) ? pwdata_i[2:0] : 3'h0;
            ev_ff <= (wr && paddr_i == EVENT_OFF && !any_reset) ? pwdata_i[4:0] : 5'h00;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~rd_ok;
            prdata_o <= 32'h0;
            if (psel_i && !penable_i && !pwrite_i)
                case (paddr_i)
                    CFG_OFF: prdata_o <= {24'h0, cfg_ff};
                    PRI_ERR_OFF: prdata_o <= {26'h0, pri_err_ff};
                    SEC_ERR_OFF: prdata_o <= {28'h0, sec_err_ff};
                    STATUS_OFF: prdata_o <= {21'h0, mode_ff, 2'h0, pwm_off_o, // see [RULE_14]
                        output_tristate_o, tristate_ctrl_ff, enable_s, // see [RULE_17]
                        ~fault_b_ff, ~fault_a_ff};
                    PIN_OFF: prdata_o <= {28'h0, disable_in_s, enable_s,
                        fault_b_pin_s, fault_a_pin_s};
                    default: prdata_o <= 32'h0;
                endcase
        end
    end
endmodule
`default_nettype wire

// [src/fault_notify_pkg.sv]
// Constants for the fault notification block: register map, fields, resets.
// Assumes a 32-bit APB slave with word-aligned registers.
package fault_notify_pkg;

    // Register byte offsets
    localparam logic [7:0] CFG_OFF = 8'h00;
    localparam logic [7:0] CTRL_OFF = 8'h04;
    localparam logic [7:0] PRI_ERR_OFF = 8'h08;
    localparam logic [7:0] SEC_ERR_OFF = 8'h0c;
    localparam logic [7:0] STATUS_OFF = 8'h10;
    localparam logic [7:0] PIN_OFF = 8'h14;
    localparam logic [7:0] EVENT_OFF = 8'h18;

    // Configuration fields
    localparam int MONITOR_DISABLE_BIT = 0;
    localparam int DISABLE_ALARM_OFF_BIT = 1;
    localparam int TRISTATE_ALARM_EN_BIT = 2;
    localparam int MONITOR_ALARM_EN_BIT = 3;
    localparam int ENABLE_SECOND_BIT = 4;

    // Control fields (write one to act, read as zero)
    localparam int CLEAR_PRIMARY_BIT_POS = 0;
    localparam int CLEAR_SECONDARY_BIT_POS = 1;
    localparam int SOFT_RESET_BIT = 2;

    // Primary error fields
    localparam int PRI_TRISTATE_BIT = 0;
    localparam int PRI_EXT_RESET_BIT = 1;
    localparam int PRI_RESET_BIT = 2;
    localparam int PRI_COMM_BIT = 3;
    localparam int PRI_CLASS_A_BIT = 4;
    localparam int PRI_CLASS_B_BIT = 5;

    // Secondary error fields
    localparam int SEC_TRISTATE_BIT = 0;
    localparam int SEC_COMM_BIT = 1;
    localparam int SEC_CLASS_A_BIT = 2;
    localparam int SEC_CLASS_B_BIT = 3;

    // Status fields
    localparam int ST_FAULT_A_BIT = 0;
    localparam int ST_FAULT_B_BIT = 1;
    localparam int ST_ENABLE_VALID_BIT = 2;
    localparam int ST_TRISTATE_CTRL_BIT = 3;
    localparam int ST_OUTPUT_HZ_BIT = 4;
    localparam int ST_PWM_OFF_BIT = 5;
    localparam int ST_MODE_LSB = 8;

    // Pin level fields
    localparam int PIN_FAULT_A_BIT = 0;
    localparam int PIN_FAULT_B_BIT = 1;
    localparam int PIN_ENABLE_BIT = 2;
    localparam int PIN_DISABLE_IN_BIT = 3;

    // Event injection fields
    localparam int EV_MONITOR_FAULT_BIT = 0;
    localparam int EV_CLASS_A_PRI_BIT = 1;
    localparam int EV_CLASS_A_SEC_BIT = 2;
    localparam int EV_CLASS_B_PRI_BIT = 3;
    localparam int EV_CLASS_B_SEC_BIT = 4;

    localparam logic [7:0] CFG_RESET = 8'h0c;
    localparam logic [5:0] PRI_ERR_RESET = 6'h00;
    localparam logic [3:0] SEC_ERR_RESET = 4'h0;

    typedef enum logic [2:0]
    {
        RESET_MODE = 3'b000,
        FAULT_MODE = 3'b001,
        DISABLED_MODE_A = 3'b011,
        ACTIVE_MODE_A = 3'b100,
        DISABLED_MODE_B = 3'b101,
        ACTIVE_MODE_B = 3'b110
    } op_mode_e;

endpackage

// [src/sync_two.sv]
// Two-stage synchroniser for a group of level inputs.
// Assumes inputs change slowly compared with the clock.
`timescale 1ns/1ps
`default_nettype none
module sync_two #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] INIT = '0
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            meta_ff <= INIT;
            q_o <= INIT;
        end
        else
        begin
            meta_ff <= d_i;
            q_o <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// [bench/fault_notify_assertions.sv]
// Checker for the fault notification block: bus, pin and reset relations.
// Assumes it is bound to fault_notify and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module fault_notify_assertions
    import fault_notify_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic enable_i,
    input wire logic output_disable_in_i,
    input wire logic primary_undervoltage_i,
    input wire logic reset_ready_n_i,
    input wire logic fault_a_n_o,
    input wire logic fault_a_n_oe_o,
    input wire logic fault_b_n_o,
    input wire logic fault_b_n_oe_o,
    input wire logic reset_ready_n_o,
    input wire logic reset_ready_n_oe_o,
    input wire logic output_tristate_o,
    input wire logic pwm_off_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////
    // Reset pin low and undervoltage excluded: set wins over clear
    sequence s_clear_primary;
        psel_i && penable_i && pwrite_i && paddr_i == CTRL_OFF
            && pwdata_i[CLEAR_PRIMARY_BIT_POS] && reset_ready_n_i && !primary_undervoltage_i;
    endsequence
    sequence s_uv_end;
        primary_undervoltage_i[*3] ##1 !primary_undervoltage_i;
    endsequence
    ////////////////////////////////////////
    property p_open_drain;
        fault_a_n_o == 1'b0 && fault_b_n_o == 1'b0 && reset_ready_n_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_ready_next;
        psel_i && !penable_i |=> pready_o;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("no zero-wait ready");
    property p_ready_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_slverr;
        pslverr_o |-> pready_o && (paddr_i > EVENT_OFF || paddr_i[1:0] != 2'b00);
    endproperty
    a_slverr: assert property (p_slverr) else $error("error on mapped address");
    property p_reset_pins;
        $fell(reset_i) |-> fault_b_n_oe_o && !fault_a_n_oe_o && reset_ready_n_oe_o && pwm_off_o;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("reset pin levels");
    property p_enable_low;
        !enable_i[*8] |-> pwm_off_o;
    endproperty
    a_enable_low: assert property (p_enable_low) else $error("active while invalid");
    property p_disable_input;
        output_disable_in_i[*6] |-> output_tristate_o;
    endproperty
    a_disable_input: assert property (p_disable_input) else $error("no tristate");
    property p_uv_pin;
        primary_undervoltage_i[*3] |-> reset_ready_n_oe_o && fault_b_n_oe_o;
    endproperty
    a_uv_pin: assert property (p_uv_pin) else $error("reset pin not driven");
    property p_clear_primary;
        s_clear_primary |-> ##[2:4] (!fault_a_n_oe_o && !fault_b_n_oe_o);
    endproperty
    a_clear_primary: assert property (p_clear_primary) else $error("pins not cleared");
    property p_uv_end;
        s_uv_end |=> fault_b_n_oe_o[*3];
    endproperty
    a_uv_end: assert property (p_uv_end) else $error("fault B dropped at end");
endmodule
`default_nettype wire

// [bench/host_model.sv]
// Host model: drives enable, pulls the open-drain pins up, can pull reset low.
// Assumes the testbench commands it through en_req_i and rst_req_i.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    input wire logic clk_i,
    input wire logic en_req_i,
    input wire logic rst_req_i,
    input wire logic fault_a_n_oe_i,
    input wire logic fault_b_n_oe_i,
    input wire logic reset_ready_n_oe_i,
    output logic enable_o,
    output logic fault_a_n_o,
    output logic fault_b_n_o,
    output logic reset_ready_n_o
);
    initial enable_o = 1'b0;
    always @(posedge clk_i)
        enable_o <= en_req_i;
    // Pull-ups: a released pin reads high
    assign fault_a_n_o = !fault_a_n_oe_i;
    assign fault_b_n_o = !fault_b_n_oe_i;
    assign reset_ready_n_o = !(reset_ready_n_oe_i || rst_req_i);
endmodule
`default_nettype wire

// [bench/fault_notify_tb.sv]
// Testbench for the fault notification block: APB tasks, directed scenarios.
// Assumes the host model drives enable and the reset pin.
`timescale 1ns/1ps
`default_nettype none
module fault_notify_tb
    import fault_notify_pkg::*;
;
    logic clk_i = 1'b0, reset_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, enable, pin_a, pin_b, pin_rst, a_oe, b_oe, r_oe, tri_st, pwm_off;
    logic output_disable_in = 1'b0, uv = 1'b0, osc_fail = 1'b0, life_lost = 1'b0;
    logic en_req = 1'b0, rst_req = 1'b0;
    int bad_count = 0, total_checks = 0;
    always #10 clk_i = ~clk_i;
    fault_notify u_fault_notify (
        .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .enable_i(enable),
        .output_disable_in_i(output_disable_in), .primary_undervoltage_i(uv),
        .primary_oscillator_fail_i(osc_fail), .lifesign_lost_i(life_lost),
        .fault_a_n_i(pin_a), .fault_b_n_i(pin_b), .reset_ready_n_i(pin_rst),
        .fault_a_n_o(), .fault_a_n_oe_o(a_oe), .fault_b_n_o(), .fault_b_n_oe_o(b_oe),
        .reset_ready_n_o(), .reset_ready_n_oe_o(r_oe), .output_tristate_o(tri_st),
        .pwm_off_o(pwm_off)
    );
    host_model u_host_model (
        .clk_i(clk_i), .en_req_i(en_req), .rst_req_i(rst_req), .fault_a_n_oe_i(a_oe),
        .fault_b_n_oe_i(b_oe), .reset_ready_n_oe_i(r_oe), .enable_o(enable),
        .fault_a_n_o(pin_a), .fault_b_n_o(pin_b), .reset_ready_n_o(pin_rst)
    );
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk(32'(pready), 1);
        if (pready !== 1'b1)
            summarize();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (4) @(posedge clk_i);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                      input logic e);
        apb(1'b0, a, 32'd0);
        chk(rd & m, x);
        chk(32'(er), 32'(e));
    endtask
    task automatic settle();
        repeat (8) @(posedge clk_i);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        rc(CFG_OFF, 32'hff, {24'd0, CFG_RESET}, 1'b0);
        rc(8'h1c, '1, 32'd0, 1'b1);
        wr(CTRL_OFF, 32'h3);
        chk(32'({a_oe, b_oe}), 0);
        rc(PRI_ERR_OFF, 32'h3f, 32'h0, 1'b0);
        rc(STATUS_OFF, 32'h700, {21'd0, DISABLED_MODE_A, 8'd0}, 1'b0);
        wr(EVENT_OFF, 32'h4);
        chk(32'(a_oe), 0);
        rc(SEC_ERR_OFF, 32'h4, 32'h4, 1'b0);
        wr(CTRL_OFF, 32'h2);
        en_req <= 1'b1;
        settle();
        rc(STATUS_OFF, 32'h704, {21'd0, ACTIVE_MODE_A, 8'h04}, 1'b0);
        rc(PIN_OFF, 32'h4, 32'h4, 1'b0);
        en_req <= 1'b0;
        settle();
        chk(32'(a_oe), 1);
        rc(STATUS_OFF, 32'h701, {21'd0, DISABLED_MODE_A, 8'd0}, 1'b0);
        rc(PIN_OFF, 32'h1, 32'h0, 1'b0);
        en_req <= 1'b1;
        settle();
        chk(32'(a_oe), 0);
        wr(EVENT_OFF, 32'h8);
        chk(32'(b_oe), 1);
        rc(STATUS_OFF, 32'h700, {21'd0, FAULT_MODE, 8'd0}, 1'b0);
        wr(EVENT_OFF, 32'h10);
        wr(CTRL_OFF, 32'h1);
        chk(32'(b_oe), 0);
        rc(SEC_ERR_OFF, 32'h8, 32'h8, 1'b0);
        wr(EVENT_OFF, 32'h10);
        chk(32'(b_oe), 0);
        wr(CTRL_OFF, 32'h2);
        rc(SEC_ERR_OFF, 32'hf, 32'h0, 1'b0);
        chk(32'(b_oe), 0);
        apb(1'b0, STATUS_OFF, 32'd0);
        chk(32'(rd[10:8] != FAULT_MODE), 1);
        wr(EVENT_OFF, 32'h1);
        chk(32'({tri_st, a_oe}), 3);
        wr(CTRL_OFF, 32'h1);
        wr(CFG_OFF, 32'h2);
        output_disable_in <= 1'b1;
        settle();
        rc(SEC_ERR_OFF, 32'h1, 32'h1, 1'b0);
        chk(32'({tri_st, a_oe}), 2);
        output_disable_in <= 1'b0;
        settle();
        wr(CFG_OFF, 32'hd);
        wr(EVENT_OFF, 32'h1);
        chk(32'({tri_st, a_oe}), 0);
        // Host-driven reset with lifesign lost
        rst_req <= 1'b1;
        life_lost <= 1'b1;
        settle();
        chk(32'({pwm_off, b_oe}), 3);
        rst_req <= 1'b0;
        settle();
        life_lost <= 1'b0;
        rc(PRI_ERR_OFF, 32'he, 32'h6, 1'b0);
        rc(SEC_ERR_OFF, 32'h2, 32'h2, 1'b0);
        rc(CFG_OFF, 32'hff, {24'd0, CFG_RESET}, 1'b0);
        chk(32'(b_oe), 1);
        for (int i = 0; i < 2; i++)
        begin
            wr(CTRL_OFF, 32'h1);
            uv <= (i == 0);
            osc_fail <= (i == 1);
            settle();
            chk(32'(r_oe), 1);
            uv <= 1'b0;
            osc_fail <= 1'b0;
            settle();
            rc(PRI_ERR_OFF, 32'he, 32'h4, 1'b0);
            chk(32'(b_oe), 1);
        end
        summarize();
    end
endmodule
bind fault_notify fault_notify_assertions u_fault_notify_assertions (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .enable_i(enable_i), .output_disable_in_i(output_disable_in_i),
    .primary_undervoltage_i(primary_undervoltage_i), .reset_ready_n_i(reset_ready_n_i),
    .fault_a_n_o(fault_a_n_o), .fault_a_n_oe_o(fault_a_n_oe_o), .fault_b_n_o(fault_b_n_o),
    .fault_b_n_oe_o(fault_b_n_oe_o), .reset_ready_n_o(reset_ready_n_o),
    .reset_ready_n_oe_o(reset_ready_n_oe_o),
    .output_tristate_o(output_tristate_o), .pwm_off_o(pwm_off_o)
);
`default_nettype wire
